// ---- include/pts_defines.svh ----
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// Widths and group sizes
`define PTS_ADC_W       10
`define PTS_NMOM        16
`define PTS_NTOG        20
`define PTS_NPAD        16
`define PTS_NCTRL       7
`define PTS_TMR_W       25
`define PTS_FTMR_W      23
`define PTS_MOVE_THR    10'h008

// Timing and clock rate
`define PTS_CLK_HZ      20000000
`define PTS_BLINK_MS    1500
`define PTS_FLASH_MS    250
`define PTS_HOLD_MS     1000
`define PTS_FULL_MS     500
`define PTS_DIM_STEP_US 4000

// Stored settings layout and factory defaults
`define PTS_SET_W       6
`define PTS_SET_PROTO   0
`define PTS_SET_STEREO  1
`define PTS_SET_MLIM    2
`define PTS_SET_MICLIM  3
`define PTS_SET_TMO     4
`define PTS_SET_DEFAULT 6'h3e

`endif

// ---- include/pts_pkg.sv ----
`include "pts_defines.svh"

package pts_pkg;

    typedef enum logic [1:0] {
        PTS_PG_VER = 2'h0,
        PTS_PG_BTN = 2'h1,
        PTS_PG_RST = 2'h2
    } pts_page_t;

    // Gray codes along blink, run, store, done, fail
    typedef enum logic [2:0] {
        PTS_PH_BLINK = 3'h0,
        PTS_PH_RUN   = 3'h1,
        PTS_PH_STORE = 3'h3,
        PTS_PH_DONE  = 3'h2,
        PTS_PH_FAIL  = 3'h6
    } pts_phase_t;

    typedef enum logic [1:0] {
        PTS_SW_IDLE = 2'h0,
        PTS_SW_FULL = 2'h1,
        PTS_SW_DIM  = 2'h3
    } pts_sweep_t;

    typedef enum logic [1:0] {
        PTS_TMO_OFF = 2'h0,
        PTS_TMO_1M  = 2'h1,
        PTS_TMO_5M  = 2'h2,
        PTS_TMO_10M = 2'h3
    } pts_timeout_t;

    typedef struct packed {
        pts_page_t                                    page;
        pts_phase_t                                   phase;
        logic [`PTS_TMR_W-1:0]                        tmr;
        logic [`PTS_FTMR_W-1:0]                       ftmr;
        logic                                         flash;
        logic                                         prev_l;
        logic                                         prev_r;
        logic                                         brw_prev;
        logic [`PTS_NTOG-1:0]                         tog_prev;
        logic [`PTS_NTOG-1:0]                         tog;
        pts_sweep_t                                   sweep;
        logic [7:0]                                   bright;
        logic [7:0]                                   pwm;
        logic [2:0]                                   enc;
        logic [1:0][`PTS_NCTRL-1:0][`PTS_ADC_W-1:0]   snap;
        logic [1:0][2:0]                              sel;
        logic [`PTS_SET_W-1:0]                        settings;
        logic                                         vendor;
        logic [2:0]                                   led_page;
        logic [`PTS_NMOM-1:0]                         led_mom;
        logic [`PTS_NTOG-1:0]                         led_tog;
        logic [1:0]                                   led_sync;
        logic [`PTS_NPAD-1:0]                         led_pad;
        logic [1:0]                                   led_marker;
        logic [1:0]                                   led_play;
        logic [3:0]                                   led_fx;
        logic [7:0]                                   led_enc;
        logic [1:0][4:0]                              led_ch;
        logic [4:0]                                   led_xf;
        logic [2:0][3:0]                              led_ver;
    } pts_state_t;

endpackage

// ---- include/pts_bar_if.sv ----
`timescale 1ns/1ps
`include "pts_defines.svh"

// Position value in, bar of lit LEDs out
interface pts_bar_if #(parameter int N = 5);
    logic [`PTS_ADC_W-1:0] value;
    logic [N-1:0]          leds;
    modport src  (output value, input leds);
    modport conv (input value, output leds);
endinterface

// ---- hw/pts_level.sv ----
`timescale 1ns/1ps
`include "pts_defines.svh"

module pts_level #(
    parameter int N = 5
) (
    pts_bar_if.conv bar
);
    localparam int PW = `PTS_ADC_W + 4;

    logic [PW-1:0] prod;
    logic [3:0]    cnt;

    // Scale to 0..N: minimum lights none, maximum all
    always_comb begin
        prod = PW'(bar.value) * PW'(N + 1);
        cnt  = prod[PW-1:`PTS_ADC_W];
    end

    // Thermometer fill from the first LED upward
    for (genvar i = 0; i < N; i++) begin : g_bit
        assign bar.leds[i] = (cnt > 4'(i)); // R9
    end
endmodule

// ---- hw/pts_top.sv ----
`timescale 1ns/1ps
`include "pts_defines.svh"
// Notes on behaviour
// R1: Left page button steps to previous page
// R2: Right page button steps to next page
// R3: New page blinks red, then tests start
// R4: Version shown as three decimal digit groups
// R5: All dark digit group means zero
// R6: Plain lit buttons light while held
// R7: Mode and pad buttons toggle their LED
// R8: Track select press: all on, dim, off
// R9: Lit LED count follows control position
// R10: Effect knob on four LEDs from left
// R11: Both encoders shown on eight LEDs
// R12: Channel controls on five LEDs per channel
// R13: Crossfader far right none, far left all
// R14: One second dual sync hold restores defaults
// R15: Both sync held lights both sync LEDs
// R16: Successful reset lights all pads red
// R17: Failed reset flashes the sync LEDs
// R18: Defaults stereo, limiters on, ten minutes idle
// R19: Auto protocol picks vendor mode when present
// R20: Hold counter restarts on any sync release
module pts_top
    import pts_pkg::*;
#(
    parameter int unsigned BLINK_CYC = `PTS_BLINK_MS * (`PTS_CLK_HZ / 1000),
    parameter int unsigned FLASH_CYC = `PTS_FLASH_MS * (`PTS_CLK_HZ / 1000),
    parameter int unsigned HOLD_CYC  = `PTS_HOLD_MS * (`PTS_CLK_HZ / 1000),
    parameter int unsigned FULL_CYC  = `PTS_FULL_MS * (`PTS_CLK_HZ / 1000),
    parameter int unsigned STEP_CYC  =
        `PTS_DIM_STEP_US * (`PTS_CLK_HZ / 1000000)
) (
    input  wire logic                                  CLOCK,
    input  wire logic                                  RST_N,
    input  wire logic                                  PAGE_PREV_BTN,
    input  wire logic                                  PAGE_NEXT_BTN,
    input  wire logic [`PTS_ADC_W-1:0]                 FW_VERSION,
    input  wire logic [`PTS_NMOM-1:0]                  BTN_MOMENT,
    input  wire logic [`PTS_NTOG-1:0]                  BTN_TOGGLE,
    input  wire logic [1:0]                            SYNC_BTN,
    input  wire logic [1:0]                            LOAD_BTN,
    input  wire logic [1:0]                            PLATTER_TOUCH,
    input  wire logic                                  TRACK_SELECT_PRESS,
    input  wire logic                                  TRACK_SELECT_CW,
    input  wire logic                                  TRACK_SELECT_CCW,
    input  wire logic                                  PLATTER_WHEEL_CW,
    input  wire logic                                  PLATTER_WHEEL_CCW,
    input  wire logic [`PTS_ADC_W-1:0]                 EFFECT_AMOUNT_ADC,
    input  wire logic [1:0][`PTS_NCTRL-1:0][`PTS_ADC_W-1:0] CH_ADC,
    input  wire logic [`PTS_ADC_W-1:0]                 XFADE_ADC,
    input  wire logic                                  STORE_ACK,
    input  wire logic                                  STORE_ERR,
    input  wire logic                                  SET_WE,
    input  wire logic [`PTS_SET_W-1:0]                 SET_DATA,
    input  wire logic                                  VENDOR_APP_PRESENT,
    output logic                                       STORE_REQ,
    output logic [`PTS_SET_W-1:0]                      SETTINGS,
    output logic                                       PROTO_GENERIC,
    output logic                                       MONO_STEREO,
    output logic                                       MASTER_LIMIT_EN,
    output logic                                       MIC_LIMIT_EN,
    output logic [1:0]                                 IDLE_SHOWCASE_TIMEOUT,
    output logic                                       VENDOR_MODE_ACTIVE,
    output logic [2:0]                                 LED_PAGE_RED,
    output logic [`PTS_NMOM-1:0]                       LED_MOMENT,
    output logic [`PTS_NTOG-1:0]                       LED_TOGGLE,
    output logic [1:0]                                 LED_SYNC,
    output logic [`PTS_NPAD-1:0]                       LED_PAD_RED,
    output logic [1:0]                                 LED_MARKER,
    output logic [1:0]                                 LED_PLAY,
    output logic [3:0]                                 LED_EFFECT,
    output logic [7:0]                                 LED_ENCODER,
    output logic [1:0][4:0]                            LED_CHANNEL,
    output logic [4:0]                                 LED_XFADE,
    output logic [2:0][3:0]                            LED_VERSION
);
    localparam int TW = `PTS_TMR_W;
    localparam int FW = `PTS_FTMR_W;

    pts_state_t      s_q;
    pts_state_t      s_d;
    logic [3:0]      fx_leds;
    logic [1:0][4:0] ch_leds;
    logic [4:0]      xf_leds;

    // Binary to three decimal digits, valid up to 999
    function automatic logic [2:0][3:0] to_dec(input logic [9:0] v);
        logic [9:0] r;
        logic [3:0] h;
        logic [3:0] t;
        r = v;
        h = 4'h0;
        t = 4'h0;
        for (int i = 0; i < 9; i++) begin
            if (r >= 10'd100) begin
                r = r - 10'd100;
                h = h + 4'h1;
            end
        end
        for (int i = 0; i < 9; i++) begin
            if (r >= 10'd10) begin
                r = r - 10'd10;
                t = t + 4'h1;
            end
        end
        return {h, t, r[3:0]};
    endfunction

    // Movement beyond a small dead band, so ADC noise does not steal focus
    function automatic logic moved(input logic [9:0] a, input logic [9:0] b);
        return (a > b) ? ((a - b) > `PTS_MOVE_THR)
                       : ((b - a) > `PTS_MOVE_THR);
    endfunction

    // Bar converters: effect knob, each channel, crossfader
    pts_bar_if #(.N(4)) fx_bar();
    assign fx_bar.value = EFFECT_AMOUNT_ADC;
    assign fx_leds      = fx_bar.leds;
    pts_level #(.N(4)) u_fx (.bar(fx_bar)); // R10

    for (genvar c = 0; c < 2; c++) begin : g_ch
        pts_bar_if #(.N(5)) bar();
        assign bar.value  = CH_ADC[c][s_q.sel[c]];
        assign ch_leds[c] = bar.leds;
        pts_level #(.N(5)) u_lvl (.bar(bar)); // R12
    end

    // ADC rises to the right, bar fills to the left
    pts_bar_if #(.N(5)) xf_bar();
    assign xf_bar.value = ~XFADE_ADC; // R13
    assign xf_leds      = xf_bar.leds;
    pts_level #(.N(5)) u_xf (.bar(xf_bar));

    // Next-state logic for the whole sequencer
    always_comb begin
        logic       rise_l;
        logic       rise_r;
        logic       both;
        logic       g_on;
        logic       g_norm;
        logic [2:0] onehot;
        rise_l = 1'b0;
        rise_r = 1'b0;
        both   = 1'b0;
        g_on   = 1'b0;
        g_norm = 1'b0;
        onehot = 3'h0;
        s_d = s_q;
        rise_l = PAGE_PREV_BTN & ~s_q.prev_l;
        rise_r = PAGE_NEXT_BTN & ~s_q.prev_r;
        both   = &SYNC_BTN;
        s_d.prev_l   = PAGE_PREV_BTN;
        s_d.prev_r   = PAGE_NEXT_BTN;
        s_d.brw_prev = TRACK_SELECT_PRESS;
        s_d.tog_prev = BTN_TOGGLE;
        s_d.pwm      = s_q.pwm + 8'h01;

        // Settings path and auto protocol choice
        if (SET_WE && s_q.phase != PTS_PH_STORE) begin
            s_d.settings = SET_DATA;
        end
        s_d.vendor = ~s_q.settings[`PTS_SET_PROTO] & VENDOR_APP_PRESENT; // R19

        // Encoder position, both encoders step one shared count; clockwise wins a tie
        if (TRACK_SELECT_CW | PLATTER_WHEEL_CW) begin
            s_d.enc = s_q.enc + 3'h1; // R11
        end else if (TRACK_SELECT_CCW | PLATTER_WHEEL_CCW) begin
            s_d.enc = s_q.enc - 3'h1; // R11
        end

        // Most recently moved control per channel owns the channel bar
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < `PTS_NCTRL; k++) begin
                if (moved(CH_ADC[c][k], s_q.snap[c][k])) begin
                    s_d.snap[c][k] = CH_ADC[c][k];
                    s_d.sel[c]     = 3'(k); // R12
                end
            end
        end

        // Phase sequencing
        case (s_q.phase)
            PTS_PH_BLINK: begin
                s_d.tmr = s_q.tmr + TW'(1);
                s_d.ftmr = s_q.ftmr + FW'(1);
                if (s_q.ftmr == FW'(FLASH_CYC - 1)) begin
                    s_d.ftmr  = '0;
                    s_d.flash = ~s_q.flash;
                end
                // Test activity waits for the blink to end dark
                if (s_q.tmr == TW'(BLINK_CYC - 1)) begin
                    s_d.tmr   = '0;
                    s_d.flash = 1'b0;
                    s_d.phase = PTS_PH_RUN; // R3
                end
            end
            PTS_PH_RUN: begin
                if (s_q.page == PTS_PG_RST) begin
                    // Any release restarts the one second hold
                    if (!both) begin
                        s_d.tmr = '0; // R20
                    end else if (s_q.tmr == TW'(HOLD_CYC - 1)) begin
                        s_d.tmr      = '0;
                        s_d.settings = `PTS_SET_DEFAULT; // R18
                        s_d.phase    = PTS_PH_STORE; // R14
                    end else begin
                        s_d.tmr = s_q.tmr + TW'(1); // R14
                    end
                end else if (s_q.page == PTS_PG_BTN) begin
                    // Toggle group flips on each press edge
                    s_d.tog = s_q.tog ^ (BTN_TOGGLE & ~s_q.tog_prev); // R7
                    case (s_q.sweep)
                        PTS_SW_IDLE: begin
                            if (TRACK_SELECT_PRESS && !s_q.brw_prev) begin
                                s_d.sweep = PTS_SW_FULL; // R8
                                s_d.tmr   = '0;
                            end
                        end
                        PTS_SW_FULL: begin
                            s_d.tmr = s_q.tmr + TW'(1);
                            if (s_q.tmr == TW'(FULL_CYC - 1)) begin
                                s_d.tmr    = '0;
                                s_d.bright = 8'hff;
                                s_d.sweep  = PTS_SW_DIM; // R8
                            end
                        end
                        PTS_SW_DIM: begin
                            s_d.tmr = s_q.tmr + TW'(1);
                            if (s_q.tmr == TW'(STEP_CYC - 1)) begin
                                s_d.tmr    = '0;
                                s_d.bright = s_q.bright - 8'h01;
                                if (s_q.bright == 8'h01) begin
                                    s_d.sweep = PTS_SW_IDLE; // R8
                                end
                            end
                        end
                        default: s_d.sweep = PTS_SW_IDLE;
                    endcase
                end
            end
            PTS_PH_STORE: begin
                // Error wins if both answers arrive together
                if (STORE_ERR) begin
                    s_d.phase = PTS_PH_FAIL; // R17
                end else if (STORE_ACK) begin
                    s_d.phase = PTS_PH_DONE; // R16
                end
            end
            PTS_PH_FAIL: begin
                s_d.ftmr = s_q.ftmr + FW'(1);
                if (s_q.ftmr == FW'(FLASH_CYC - 1)) begin
                    s_d.ftmr  = '0;
                    s_d.flash = ~s_q.flash; // R17
                end
            end
            PTS_PH_DONE: begin
            end
            default: s_d.phase = PTS_PH_BLINK;
        endcase

        // Page stepping; a store in flight is never abandoned
        if (s_q.phase != PTS_PH_STORE && (rise_l ^ rise_r)) begin
            case (s_q.page)
                PTS_PG_VER: s_d.page = rise_l ? PTS_PG_RST : PTS_PG_BTN;
                PTS_PG_BTN: s_d.page = rise_l ? PTS_PG_VER : PTS_PG_RST;
                default:    s_d.page = rise_l ? PTS_PG_BTN : PTS_PG_VER;
            endcase // R1 R2
            s_d.phase = PTS_PH_BLINK; // R3
            s_d.tmr   = '0;
            s_d.ftmr  = '0;
            s_d.flash = 1'b1;
            s_d.tog   = '0;
            s_d.sweep = PTS_SW_IDLE;
        end

        // LED images, all registered
        case (s_d.page)
            PTS_PG_VER: onehot = 3'h1;
            PTS_PG_BTN: onehot = 3'h2;
            default:    onehot = 3'h4;
        endcase
        s_d.led_page = (s_d.phase == PTS_PH_BLINK && s_d.flash) ?
                       onehot : 3'h0; // R3
        g_norm = (s_q.sweep == PTS_SW_IDLE);
        g_on   = (s_q.sweep == PTS_SW_FULL) ||
                 (s_q.bright > s_q.pwm);
        s_d.led_mom    = '0;
        s_d.led_tog    = '0;
        s_d.led_sync   = 2'h0;
        s_d.led_pad    = '0;
        s_d.led_marker = 2'h0;
        s_d.led_play   = 2'h0;
        s_d.led_fx     = 4'h0;
        s_d.led_enc    = 8'h00;
        s_d.led_ch     = '0;
        s_d.led_xf     = 5'h00;
        s_d.led_ver    = '0;
        if (s_d.phase != PTS_PH_BLINK) begin
            if (s_d.page == PTS_PG_VER) begin
                // Binary count per group, so zero leaves it dark
                s_d.led_ver = to_dec(FW_VERSION); // R4 R5
            end else if (s_d.page == PTS_PG_BTN) begin
                s_d.led_mom = g_norm ? BTN_MOMENT : {`PTS_NMOM{g_on}}; // R6
                s_d.led_tog = g_norm ? s_d.tog : {`PTS_NTOG{g_on}}; // R7
                s_d.led_sync   = g_norm ? SYNC_BTN : {2{g_on}};
                s_d.led_marker = g_norm ? LOAD_BTN : {2{g_on}};
                s_d.led_play   = g_norm ? PLATTER_TOUCH : {2{g_on}};
                s_d.led_fx  = g_norm ? fx_leds : {4{g_on}}; // R10
                s_d.led_enc = g_norm ? (8'h01 << s_d.enc) : {8{g_on}};
                s_d.led_ch  = g_norm ? ch_leds : {10{g_on}}; // R12
                s_d.led_xf  = g_norm ? xf_leds : {5{g_on}}; // R13
            end else begin
                if (s_d.phase == PTS_PH_FAIL) begin
                    s_d.led_sync = {2{s_d.flash}}; // R17
                end else if (both) begin
                    s_d.led_sync = 2'h3; // R15
                end
                if (s_d.phase == PTS_PH_DONE) begin
                    s_d.led_pad = '1; // R16
                end
            end
        end
    end

    // Single state register; reset loads factory defaults
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.settings <= `PTS_SET_DEFAULT; // R18
            s_q.flash    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Port drive straight from the state register
    assign STORE_REQ             = (s_q.phase == PTS_PH_STORE);
    assign SETTINGS              = s_q.settings;
    assign PROTO_GENERIC         = s_q.settings[`PTS_SET_PROTO];
    assign MONO_STEREO           = s_q.settings[`PTS_SET_STEREO];
    assign MASTER_LIMIT_EN       = s_q.settings[`PTS_SET_MLIM];
    assign MIC_LIMIT_EN          = s_q.settings[`PTS_SET_MICLIM];
    assign IDLE_SHOWCASE_TIMEOUT = s_q.settings[`PTS_SET_TMO +: 2];
    assign VENDOR_MODE_ACTIVE    = s_q.vendor;
    assign LED_PAGE_RED          = s_q.led_page;
    assign LED_MOMENT            = s_q.led_mom;
    assign LED_TOGGLE            = s_q.led_tog;
    assign LED_SYNC              = s_q.led_sync;
    assign LED_PAD_RED           = s_q.led_pad;
    assign LED_MARKER            = s_q.led_marker;
    assign LED_PLAY              = s_q.led_play;
    assign LED_EFFECT            = s_q.led_fx;
    assign LED_ENCODER           = s_q.led_enc;
    assign LED_CHANNEL           = s_q.led_ch;
    assign LED_XFADE             = s_q.led_xf;
    assign LED_VERSION           = s_q.led_ver;
endmodule

// ---- tb/pts_store_model.sv ----
`timescale 1ns/1ps
// Settings store: answers after dly cycles, may refuse
module pts_store_model (
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       fail,
    input  wire logic [3:0] dly,
    output logic            ack,
    output logic            err
);
    int cnt;

    initial begin
        ack = 1'b0;
        err = 1'b0;
    end

    // One answer pulse per request, on the falling edge
    always @(negedge clk) begin
        ack <= 1'b0;
        err <= 1'b0;
        cnt <= req ? cnt + 1 : 0;
        if (req && cnt == int'(dly)) begin
            ack <= !fail;
            err <= fail;
        end
    end
endmodule

// ---- tb/pts_top_monitor.sv ----
`timescale 1ns/1ps
// Top ports only; page and phase inferred from LEDs
module pts_top_monitor (
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic        PAGE_PREV_BTN,
    input wire logic        PAGE_NEXT_BTN,
    input wire logic [1:0]  SYNC_BTN,
    input wire logic        STORE_ACK,
    input wire logic        STORE_ERR,
    input wire logic        VENDOR_APP_PRESENT,
    input wire logic        STORE_REQ,
    input wire logic [5:0]  SETTINGS,
    input wire logic        MONO_STEREO,
    input wire logic        MIC_LIMIT_EN,
    input wire logic [1:0]  IDLE_SHOWCASE_TIMEOUT,
    input wire logic        VENDOR_MODE_ACTIVE,
    input wire logic [2:0]  LED_PAGE_RED,
    input wire logic [15:0] LED_MOMENT,
    input wire logic [15:0] LED_PAD_RED
);
    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    // Store handshake and its results
    property p_end;
        STORE_REQ && (STORE_ACK || STORE_ERR) |=> !STORE_REQ;
    endproperty
    a_end: assert property (p_end) else $error("store req stuck");
    property p_pads;
        STORE_REQ && STORE_ACK && !STORE_ERR |=> ##1 LED_PAD_RED == '1;
    endproperty
    a_pads: assert property (p_pads) else $error("pads dark");
    property p_dflt;
        $rose(STORE_REQ) |-> ##[0:1] SETTINGS == 6'h3e;
    endproperty
    a_dflt: assert property (p_dflt) else $error("no defaults");
    // Store starts only after a sustained hold
    property p_hold;
        $rose(STORE_REQ) |-> $past(SYNC_BTN) == 2'b11
            && $past(SYNC_BTN, 8) == 2'b11;
    endproperty
    a_hold: assert property (p_hold) else $error("short hold");
    property p_flds;
        {IDLE_SHOWCASE_TIMEOUT, MIC_LIMIT_EN, MONO_STEREO} ==
            {SETTINGS[5:4], SETTINGS[3], SETTINGS[1]};
    endproperty
    a_flds: assert property (p_flds) else $error("field split");
    property p_vend;
        $past(RST_N) |-> VENDOR_MODE_ACTIVE ==
            (!$past(SETTINGS[0]) && $past(VENDOR_APP_PRESENT));
    endproperty
    a_vend: assert property (p_vend) else $error("proto pick");
    // Page entry blinks, test LEDs dark meanwhile
    property p_blnk;
        $rose(PAGE_NEXT_BTN) && !PAGE_PREV_BTN && !STORE_REQ
            |-> ##[1:3] $onehot(LED_PAGE_RED);
    endproperty
    a_blnk: assert property (p_blnk) else $error("no blink");
    property p_dark;
        LED_PAGE_RED != 3'h0 && $past(LED_PAGE_RED) != 3'h0
            |-> LED_MOMENT == '0 && LED_PAD_RED == '0;
    endproperty
    a_dark: assert property (p_dark) else $error("lit in blink");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import pts_pkg::*;
;
    logic                 clk, rst_n, pp, pn, ts, tcw, pccw, we, ven, fl;
    logic [9:0]           fw, fx;
    logic [15:0]          bm;
    logic [19:0]          bt, et;
    logic                 tccw, pcw;
    logic [1:0]           sy, ld, pt;
    logic [5:0]           sd;
    logic [3:0]           dl;
    logic [1:0][6:0][9:0] ch;
    wire                  rq, ak, er, va;
    wire [5:0]            st;
    wire [2:0]            pg;
    wire [15:0]           lm, lp;
    wire [19:0]           lt;
    wire [1:0]            ls, lk, ly;
    wire [3:0]            le;
    wire [7:0]            lc;
    wire [1:0][4:0]       lh;
    wire [4:0]            lx;
    wire [11:0]           lv;
    int                   fails, n_compared, seed, v, j;

    // Short counts keep the run brief
    pts_top #(.BLINK_CYC(64), .FLASH_CYC(8), .HOLD_CYC(40), .FULL_CYC(16),
        .STEP_CYC(2)) u_pts_top (.CLOCK(clk), .RST_N(rst_n),
        .PAGE_PREV_BTN(pp), .PAGE_NEXT_BTN(pn), .FW_VERSION(fw),
        .BTN_MOMENT(bm), .BTN_TOGGLE(bt), .SYNC_BTN(sy), .LOAD_BTN(ld),
        .PLATTER_TOUCH(pt), .TRACK_SELECT_PRESS(ts), .TRACK_SELECT_CW(tcw),
        .TRACK_SELECT_CCW(tccw), .PLATTER_WHEEL_CW(pcw),
        .PLATTER_WHEEL_CCW(pccw), .EFFECT_AMOUNT_ADC(fx), .CH_ADC(ch),
        .XFADE_ADC(fx), .STORE_ACK(ak), .STORE_ERR(er), .SET_WE(we),
        .SET_DATA(sd), .VENDOR_APP_PRESENT(ven), .STORE_REQ(rq),
        .SETTINGS(st), .PROTO_GENERIC(), .MONO_STEREO(), .MASTER_LIMIT_EN(),
        .MIC_LIMIT_EN(), .IDLE_SHOWCASE_TIMEOUT(), .VENDOR_MODE_ACTIVE(va),
        .LED_PAGE_RED(pg), .LED_MOMENT(lm), .LED_TOGGLE(lt), .LED_SYNC(ls),
        .LED_PAD_RED(lp), .LED_MARKER(lk), .LED_PLAY(ly), .LED_EFFECT(le),
        .LED_ENCODER(lc), .LED_CHANNEL(lh), .LED_XFADE(lx),
        .LED_VERSION(lv));
    pts_store_model u_pts_store_model (.clk(clk), .req(rq), .fail(fl),
        .dly(dl), .ack(ak), .err(er));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up;
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Expected bar: (a*(n+1))>>10 LEDs lit
    function automatic logic [7:0] bar(input logic [9:0] a, input int n);
        bar = (8'h01 << ((int'(a) * (n + 1)) >> 10)) - 8'h01;
    endfunction
    // Page step, blink seen then expired
    task automatic page(input logic nx, input logic [2:0] e);
        pn = nx;
        pp = !nx;
        cy(2);
        chk(pg, e);
        {pn, pp} = 2'b00;
        cy(70);
        chk(pg, 3'h0);
    endtask
    // Bounded two-sync hold until store starts
    task automatic hold;
        sy = 2'b11;
        for (j = 0; j < 60 && rq !== 1'b1; j++) cy(1);
        if (rq !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask

    initial begin
        seed = 27;
        {rst_n, pp, pn, ts, tcw, pccw, we, ven, fl, fw, fx} = '0;
        {bm, bt, et, sy, ld, pt, sd, dl, ch, tccw, pcw} = '0;
        cy(4);
        rst_n = 1'b1;
        cy(1);
        chk(pg, 3'h1);
        chk(st, 6'h3e);
        cy(70);
        for (int k = 0; k < 5; k++) begin
            v = k == 0 ? 0 : k == 1 ? 999 : $unsigned($random(seed)) % 1000;
            fw = v[9:0];
            cy(3);
            chk(lv, {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)});
        end
        page(1'b1, 3'h2);
        for (int k = 0; k < 6; k++) begin
            bm = 16'($random(seed));
            ld = 2'($random(seed));
            pt = 2'($random(seed));
            if (k != 1) j = $unsigned($random(seed)) % 20;
            bt[j] = 1'b1;
            cy(2);
            bt = '0;
            et[j] = !et[j];
            cy(2);
            chk(lm, bm);
            chk(lk, ld);
            chk(ly, pt);
            chk(lt, et);
            fx = k == 0 ? 10'h000 : k == 1 ? 10'h3ff : 10'($random(seed));
            ch[1][0] = fx;
            ch[0][0] = ~fx;
            cy(3);
            chk(le, bar(fx, 4));
            chk(lx, bar(~fx, 5));
            chk(lh, {5'(bar(fx, 5)), 5'(bar(~fx, 5))});
        end
        // Mixed steps on both encoders, net one clockwise
        for (int k = 0; k < 5; k++) begin
            tcw = k < 2;
            pcw = k == 2;
            tccw = k == 3;
            pccw = k == 4;
            cy(1);
            {tcw, pcw, tccw, pccw} = 4'h0;
            cy(1);
        end
        cy(2);
        chk(lc, 8'h02);
        ts = 1'b1;
        cy(3);
        chk(lm, 16'hffff);
        ts = 1'b0;
        cy(560);
        chk(lm, bm);
        page(1'b0, 3'h1);
        page(1'b0, 3'h4);
        sd = {4'($random(seed)), 2'b01};
        ven = 1'b1;
        we = 1'b1;
        cy(1);
        we = 1'b0;
        cy(2);
        chk(st, sd);
        chk(va, 1'b0);
        sy = 2'b11;
        cy(20);
        chk(ls, 2'b11);
        sy = 2'b10;
        cy(1);
        sy = 2'b11;
        cy(30);
        chk(rq, 1'b0);
        hold();
        cy(4);
        chk(lp, 16'hffff);
        chk(st, 6'h3e);
        chk(va, 1'b1);
        sy = 2'b00;
        page(1'b1, 3'h1);
        page(1'b0, 3'h4);
        fl = 1'b1;
        dl = 4'h9;
        hold();
        sy = 2'b00;
        cy(14);
        v = ls;
        cy(8);
        chk(ls != v[1:0], 1'b1);
        wrap_up();
    end
endmodule

bind pts_top pts_top_monitor u_pts_top_monitor (.*);
